// ### hw/cwcs_pkg.sv
`default_nettype none
package cwcs_pkg;
	// ------------------------------------------------------------
	// word layout
	// ------------------------------------------------------------
	localparam logic [13:0] CWCS_WORD_ADDR = 14'h2007;
	localparam logic [13:0] CWCS_WORD_RESET = 14'h3fff;
	localparam logic [13:0] CWCS_UNIMPL_MASK = 14'h0880;
	localparam int CWCS_FOSC_LSB = 0;
	localparam int CWCS_WATCHDOG_ENABLE_BIT_BIT = 3;
	localparam int CWCS_POWERUP_DELAY_ENABLE_BIT = 4;
	localparam int CWCS_MASTER_RESET_PIN_SELECT_BIT = 5;
	localparam int CWCS_CP_BIT = 6;
	localparam int CWCS_BOREN_LSB = 8;
	localparam int CWCS_BORV_BIT = 10;
	localparam int CWCS_PLL_BIT = 12;
	localparam int CWCS_DEBUG_BIT = 13;
	localparam logic [10:0] CWCS_OST_COUNT = 11'h400;
	localparam logic [2:0] CWCS_RC_OUT = 3'h7;
	localparam logic [2:0] CWCS_RC_IO = 3'h6;
	localparam logic [2:0] CWCS_INT_OUT = 3'h5;
	localparam logic [2:0] CWCS_INT_IO = 3'h4;
	localparam logic [2:0] CWCS_EC = 3'h3;
	localparam logic [2:0] CWCS_HS = 3'h2;
	localparam logic [2:0] CWCS_XT = 3'h1;
	localparam logic [2:0] CWCS_LP = 3'h0;

	typedef enum logic [1:0] {
		CWCS_SRC_CRYSTAL,
		CWCS_SRC_RC,
		CWCS_SRC_INTERNAL,
		CWCS_SRC_DRIVEN
	} cwcs_src_t;

	typedef struct packed {
		cwcs_src_t src;
		logic [1:0] xtal_gain;
		logic quarter_rate_clock_output_en;
		logic oscillator_input_pin_io;
		logic oscillator_output_pin_io;
	} cwcs_clk_t;

	typedef struct packed {
		logic debug_en;
		logic pll_16mhz;
		logic borv_high;
		logic [1:0] bor_mode;
		logic code_protect;
		logic master_reset_pin_select;
		logic powerup_delay_enable;
		logic watchdog_enable_bit;
	} cwcs_misc_t;

	function automatic cwcs_clk_t cwcs_decode(input logic [2:0] f);
		cwcs_clk_t c;
		c = '{CWCS_SRC_CRYSTAL, 2'h0, 1'b0, 1'b0, 1'b0};
		unique case (f)
			CWCS_RC_OUT: c = '{CWCS_SRC_RC, 2'h0, 1'b1, 1'b0, 1'b0};
			CWCS_RC_IO: c = '{CWCS_SRC_RC, 2'h0, 1'b0, 1'b0, 1'b1};
			CWCS_INT_OUT: c = '{CWCS_SRC_INTERNAL, 2'h0, 1'b1, 1'b1, 1'b0};
			CWCS_INT_IO: c = '{CWCS_SRC_INTERNAL, 2'h0, 1'b0, 1'b1, 1'b1};
			CWCS_EC: c = '{CWCS_SRC_DRIVEN, 2'h0, 1'b0, 1'b0, 1'b1};
			CWCS_HS: c = '{CWCS_SRC_CRYSTAL, 2'h2, 1'b0, 1'b0, 1'b0};
			CWCS_XT: c = '{CWCS_SRC_CRYSTAL, 2'h1, 1'b0, 1'b0, 1'b0};
			CWCS_LP: c = '{CWCS_SRC_CRYSTAL, 2'h0, 1'b0, 1'b0, 1'b0};
		endcase
		return c;
	endfunction
endpackage
`default_nettype wire

// ### hw/cwcs_config_word.sv
`default_nettype none
module cwcs_config_word
	import cwcs_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic prog_mode,
	input wire logic [13:0] prog_addr,
	input wire logic prog_wr,
	input wire logic [13:0] prog_wdata,
	output logic [13:0] prog_rdata,
	output logic erase_all,
	input wire logic oscillator_input_pin_edge,
	input wire logic start_req,
	input wire logic master_reset_pin,
	output cwcs_clk_t clk_cfg,
	output cwcs_misc_t misc_cfg,
	output logic int_osc_run,
	output logic quarter_rate_clock_output,
	output logic exec_hold
);
	// ------------------------------------------------------------
	// word storage
	// ------------------------------------------------------------
	logic [13:0] word_ff, nxt_word;
	logic erase_ff, nxt_erase;
	logic hit;
	assign hit = prog_mode && (prog_addr == CWCS_WORD_ADDR);
	always_comb
	begin
		nxt_word = word_ff;
		nxt_erase = 1'b0;
		if (hit && prog_wr)
		begin
			nxt_word = prog_wdata | CWCS_UNIMPL_MASK;
			// protection bit is active low: 0 -> 1 means protection turned off
			nxt_erase = !word_ff[CWCS_CP_BIT] && prog_wdata[CWCS_CP_BIT];
		end
	end
	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
		begin
			word_ff <= CWCS_WORD_RESET;
			erase_ff <= 1'b0;
		end
		else
		begin
			word_ff <= nxt_word;
			erase_ff <= nxt_erase;
		end
	assign erase_all = erase_ff;
	// reads outside programming mode return zero, never the word
	assign prog_rdata = hit ? word_ff : 14'h0000;

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	assign clk_cfg = cwcs_decode(word_ff[CWCS_FOSC_LSB +: 3]);
	assign misc_cfg = '{word_ff[CWCS_DEBUG_BIT], word_ff[CWCS_PLL_BIT],
		word_ff[CWCS_BORV_BIT], word_ff[CWCS_BOREN_LSB +: 2],
		word_ff[CWCS_CP_BIT], word_ff[CWCS_MASTER_RESET_PIN_SELECT_BIT],
		word_ff[CWCS_POWERUP_DELAY_ENABLE_BIT], word_ff[CWCS_WATCHDOG_ENABLE_BIT_BIT]};
	// reset pin active low, and only a reset when the pin function is selected
	assign int_osc_run = !((clk_cfg.src == CWCS_SRC_INTERNAL || clk_cfg.src == CWCS_SRC_RC)
		&& word_ff[CWCS_MASTER_RESET_PIN_SELECT_BIT] && !master_reset_pin);

	// ------------------------------------------------------------
	// start-up count and clock out
	// ------------------------------------------------------------
	logic [10:0] ost_ff, nxt_ost;
	logic [1:0] div_ff, nxt_div;
	logic out_ff, nxt_out;
	always_comb
	begin
		nxt_ost = ost_ff;
		if (start_req)
			nxt_ost = (clk_cfg.src == CWCS_SRC_CRYSTAL) ? CWCS_OST_COUNT : 11'h000;
		else if (ost_ff != 11'h000 && oscillator_input_pin_edge)
			nxt_ost = ost_ff - 11'h001;
		nxt_div = int_osc_run ? div_ff + 2'h1 : div_ff;
		nxt_out = clk_cfg.quarter_rate_clock_output_en && div_ff[1];
	end
	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
		begin
			ost_ff <= 11'h000;
			div_ff <= 2'h0;
			out_ff <= 1'b0;
		end
		else
		begin
			ost_ff <= nxt_ost;
			div_ff <= nxt_div;
			out_ff <= nxt_out;
		end
	assign exec_hold = (ost_ff != 11'h000);
	assign quarter_rate_clock_output = out_ff;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_ec_nodelay;
		@(posedge ref_clk) disable iff (!rst_n)
		start_req && clk_cfg.src == CWCS_SRC_DRIVEN |=> !exec_hold;
	endproperty
	a_ec_nodelay: assert property (p_ec_nodelay) else $error("driven clock delayed");
	property p_ost;
		@(posedge ref_clk) disable iff (!rst_n)
		start_req && clk_cfg.src == CWCS_SRC_CRYSTAL |=> ost_ff == CWCS_OST_COUNT;
	endproperty
	a_ost: assert property (p_ost) else $error("start count wrong");
	property p_erase;
		@(posedge ref_clk) disable iff (!rst_n)
		hit && prog_wr && !word_ff[CWCS_CP_BIT] && prog_wdata[CWCS_CP_BIT] |=> erase_all;
	endproperty
	a_erase: assert property (p_erase) else $error("no erase");
	property p_locked;
		@(posedge ref_clk) disable iff (!rst_n)
		!prog_mode |=> word_ff == $past(word_ff);
	endproperty
	a_locked: assert property (p_locked) else $error("word changed at run");
	property p_unimpl;
		@(posedge ref_clk) disable iff (!rst_n)
		(word_ff & CWCS_UNIMPL_MASK) == CWCS_UNIMPL_MASK;
	endproperty
	a_unimpl: assert property (p_unimpl) else $error("unimplemented bit low");
	property p_gate;
		@(posedge ref_clk) disable iff (!rst_n)
		clk_cfg.src == CWCS_SRC_RC && word_ff[CWCS_MASTER_RESET_PIN_SELECT_BIT] && !master_reset_pin
		|-> !int_osc_run;
	endproperty
	a_gate: assert property (p_gate) else $error("osc not gated");
	property p_io_out;
		@(posedge ref_clk) disable iff (!rst_n)
		clk_cfg.oscillator_output_pin_io |=> !quarter_rate_clock_output;
	endproperty
	a_io_out: assert property (p_io_out) else $error("clock on io pin");
	property p_pwrt;
		@(posedge ref_clk) disable iff (!rst_n)
		misc_cfg.powerup_delay_enable == word_ff[CWCS_POWERUP_DELAY_ENABLE_BIT];
	endproperty
	a_pwrt: assert property (p_pwrt) else $error("pwrt tied to bor");

	// ------------------------------------------------------------
	// mode decode and counter checks
	// ------------------------------------------------------------
	logic [2:0] fosc;
	assign fosc = word_ff[CWCS_FOSC_LSB +: 3];
	property p_rc_out;
		@(posedge ref_clk) disable iff (!rst_n)
		fosc == CWCS_RC_OUT |-> clk_cfg.src == CWCS_SRC_RC && clk_cfg.quarter_rate_clock_output_en && !clk_cfg.oscillator_output_pin_io;
	endproperty
	a_rc_out: assert property (p_rc_out) else $error("rc clock out mode wrong");
	property p_rc_io;
		@(posedge ref_clk) disable iff (!rst_n)
		fosc == CWCS_RC_IO |-> clk_cfg.src == CWCS_SRC_RC && !clk_cfg.quarter_rate_clock_output_en && clk_cfg.oscillator_output_pin_io;
	endproperty
	a_rc_io: assert property (p_rc_io) else $error("rc io mode wrong");
	property p_int_out;
		@(posedge ref_clk) disable iff (!rst_n)
		fosc == CWCS_INT_OUT |-> clk_cfg.src == CWCS_SRC_INTERNAL && clk_cfg.quarter_rate_clock_output_en && clk_cfg.oscillator_input_pin_io;
	endproperty
	a_int_out: assert property (p_int_out) else $error("internal clock out mode wrong");
	property p_int_io;
		@(posedge ref_clk) disable iff (!rst_n)
		fosc == CWCS_INT_IO |-> clk_cfg.src == CWCS_SRC_INTERNAL && clk_cfg.oscillator_input_pin_io && clk_cfg.oscillator_output_pin_io;
	endproperty
	a_int_io: assert property (p_int_io) else $error("internal io mode wrong");
	property p_ec_mode;
		@(posedge ref_clk) disable iff (!rst_n)
		fosc == CWCS_EC |-> clk_cfg.src == CWCS_SRC_DRIVEN && !clk_cfg.oscillator_input_pin_io && clk_cfg.oscillator_output_pin_io;
	endproperty
	a_ec_mode: assert property (p_ec_mode) else $error("driven clock mode wrong");
	property p_hs_mode;
		@(posedge ref_clk) disable iff (!rst_n)
		fosc == CWCS_HS |-> clk_cfg.src == CWCS_SRC_CRYSTAL && clk_cfg.xtal_gain == 2'h2;
	endproperty
	a_hs_mode: assert property (p_hs_mode) else $error("high gain mode wrong");
	property p_xt_mode;
		@(posedge ref_clk) disable iff (!rst_n)
		fosc == CWCS_XT |-> clk_cfg.src == CWCS_SRC_CRYSTAL && clk_cfg.xtal_gain == 2'h1;
	endproperty
	a_xt_mode: assert property (p_xt_mode) else $error("medium gain mode wrong");
	property p_lp_mode;
		@(posedge ref_clk) disable iff (!rst_n)
		fosc == CWCS_LP |-> clk_cfg.src == CWCS_SRC_CRYSTAL && clk_cfg.xtal_gain == 2'h0;
	endproperty
	a_lp_mode: assert property (p_lp_mode) else $error("low gain mode wrong");
	property p_erase_pulse;
		@(posedge ref_clk) disable iff (!rst_n)
		erase_all |=> !erase_all;
	endproperty
	a_erase_pulse: assert property (p_erase_pulse) else $error("erase longer than one cycle");
	property p_no_erase;
		@(posedge ref_clk) disable iff (!rst_n)
		!(hit && prog_wr) |=> !erase_all;
	endproperty
	a_no_erase: assert property (p_no_erase) else $error("erase without write");
	property p_read_lock;
		@(posedge ref_clk) disable iff (!rst_n)
		!prog_mode |-> prog_rdata == 14'h0000;
	endproperty
	a_read_lock: assert property (p_read_lock) else $error("word readable at run");
	property p_count_down;
		@(posedge ref_clk) disable iff (!rst_n)
		exec_hold && !start_req && oscillator_input_pin_edge |=> ost_ff == $past(ost_ff) - 11'h001;
	endproperty
	a_count_down: assert property (p_count_down) else $error("start count missed edge");
	property p_count_hold;
		@(posedge ref_clk) disable iff (!rst_n)
		!start_req && !oscillator_input_pin_edge |=> ost_ff == $past(ost_ff);
	endproperty
	a_count_hold: assert property (p_count_hold) else $error("start count moved alone");
	property p_gate_int;
		@(posedge ref_clk) disable iff (!rst_n)
		clk_cfg.src == CWCS_SRC_INTERNAL && word_ff[CWCS_MASTER_RESET_PIN_SELECT_BIT] && !master_reset_pin
		|-> !int_osc_run;
	endproperty
	a_gate_int: assert property (p_gate_int) else $error("internal osc not gated");
	property p_no_gate;
		@(posedge ref_clk) disable iff (!rst_n)
		!word_ff[CWCS_MASTER_RESET_PIN_SELECT_BIT] |-> int_osc_run;
	endproperty
	a_no_gate: assert property (p_no_gate) else $error("osc gated with pin as io");
	property p_div_stop;
		@(posedge ref_clk) disable iff (!rst_n)
		!int_osc_run |=> div_ff == $past(div_ff);
	endproperty
	a_div_stop: assert property (p_div_stop) else $error("divider ran while gated");
endmodule
`default_nettype wire

// ### sim/cwcs_xtal_model.sv
`default_nettype none
module cwcs_xtal_model
(
	input wire logic ref_clk,
	input wire logic run,
	output logic oscillator_input_pin_edge
);
	timeunit 1ns;
	timeprecision 1ps;
	logic ph = 1'b0;
	// one swing every second clock; still while not run
	always @(posedge ref_clk)
	begin
		ph <= run & ~ph;
		oscillator_input_pin_edge <= run & ~ph;
	end
endmodule
`default_nettype wire

// ### sim/tb_config_word_clock_select.sv
`default_nettype none
module tb_config_word_clock_select
	import cwcs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'b0, rst_n = 1'b0, prog_mode = 1'b0, prog_wr = 1'b0, start_req = 1'b0;
	logic master_reset_pin = 1'b1, run = 1'b0, oscillator_input_pin_edge;
	logic erase_all, int_osc_run, quarter_rate_clock_output, exec_hold;
	logic [13:0] prog_addr = 14'h0, prog_wdata = 14'h0, prog_rdata, cur = 14'h3fff;
	cwcs_clk_t clk_cfg;
	cwcs_misc_t misc_cfg;
	int n_mismatch = 0, n_checks = 0;
	bit q[$];
	// src, gain, clock out, pin one io, pin two io per field code
	logic [6:0] tbl [8] = '{7'h00, 7'h08, 7'h10, 7'h61, 7'h43, 7'h46, 7'h21, 7'h24};
	cwcs_config_word dut_u (.ref_clk, .rst_n, .prog_mode, .prog_addr, .prog_wr, .prog_wdata,
		.prog_rdata, .erase_all, .oscillator_input_pin_edge, .start_req, .master_reset_pin, .clk_cfg,
		.misc_cfg, .int_osc_run, .quarter_rate_clock_output, .exec_hold);
	cwcs_xtal_model osc_u (.ref_clk, .run, .oscillator_input_pin_edge);
	always #2 ref_clk = ~ref_clk;
	task automatic chk(input logic [13:0] got, input logic [13:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic final_report;
		if (n_mismatch == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic wr(input logic m, input logic [13:0] a, input logic [13:0] w);
		@(posedge ref_clk);
		prog_mode <= m;
		prog_addr <= a;
		prog_wdata <= w;
		prog_wr <= 1'b1;
		if (m && a == CWCS_WORD_ADDR && !cur[6] && w[6])
			q.push_back(1'b1);
		if (m && a == CWCS_WORD_ADDR)
			cur = w | CWCS_UNIMPL_MASK;
		@(posedge ref_clk);
		prog_wr <= 1'b0;
		prog_mode <= 1'b1;
		prog_addr <= CWCS_WORD_ADDR;
		#1;
	endtask
	// erase pulses are matched against the oldest note
	always @(posedge ref_clk)
		if (erase_all === 1'b1)
		begin
			n_checks++;
			if (q.size() == 0)
			begin
				n_mismatch++;
				$display("MISMATCH %0t stray erase", $time);
			end
			else
				void'(q.pop_front());
		end
	initial
	begin
		#100000;
		n_mismatch++;
		final_report();
	end
	initial
	begin
		int k;
		logic [13:0] w;
		void'($urandom(61510));
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'b1;
		wr(1'b0, CWCS_WORD_ADDR, 14'h0);
		chk(prog_rdata, 14'h3fff);
		for (int i = 0; i < 8; i++)
		begin
			w = 14'($urandom);
			w[2:0] = 3'(i);
			wr(1'b1, CWCS_WORD_ADDR, w);
			chk(prog_rdata, w | CWCS_UNIMPL_MASK);
			chk(14'(clk_cfg), 14'(tbl[i]));
			chk(14'(misc_cfg), 14'({w[13:12], w[10:8], w[6:3]}));
		end
		wr(1'b1, CWCS_WORD_ADDR, 14'h3fbf);
		wr(1'b1, CWCS_WORD_ADDR, 14'h3fff);
		wr(1'b1, 14'h2008, 14'h0);
		chk(prog_rdata, 14'h3fff);
		for (int j = 0; j < 2; j++)
		begin
			k = 0;
			repeat (32) @(posedge ref_clk) k += int'(quarter_rate_clock_output === 1'b1);
			chk(14'(k), j ? 14'h0 : 14'h10);
			master_reset_pin <= 1'b0;
			@(posedge ref_clk);
			#1;
			chk(14'(int_osc_run), j ? 14'h1 : 14'h0);
			master_reset_pin <= 1'b1;
			wr(1'b1, CWCS_WORD_ADDR, 14'h3ffa);
		end
		prog_mode <= 1'b0;
		start_req <= 1'b1;
		@(posedge ref_clk);
		start_req <= 1'b0;
		run <= 1'b1;
		#1;
		chk(prog_rdata, 14'h0);
		chk(14'(exec_hold), 14'h1);
		k = 0;
		while (exec_hold === 1'b1 && k < 2000)
		begin
			@(posedge ref_clk);
			k += int'(oscillator_input_pin_edge === 1'b1);
			#1;
		end
		chk(14'(k), 14'h400);
		wr(1'b1, CWCS_WORD_ADDR, 14'h3ffb);
		start_req <= 1'b1;
		@(posedge ref_clk);
		start_req <= 1'b0;
		#1;
		chk(14'(exec_hold), 14'h0);
		chk(14'(q.size()), 14'h0);
		final_report();
	end
endmodule
`default_nettype wire
